// *** core/ppm_pkg.sv ***
// Purpose: Constants and carrier types for the port pin mux and reset block
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes:   Pin select codes and reset stretch counts live here
// Operation
// - Second port pin 4 in its reset function drives a level showing the device is in reset.
// - With the PLL off the reset level is held about 512 clocks after external reset release.
// - With the PLL on the reset level is held 100 us times the VCO to crystal ratio after release.
// - After reset second port pin 4 is an output in its active state, not an input.
// - Second port pins 3 to 0 can act as level-sensitive interrupt request inputs.
// - Those interrupt inputs are asynchronous and are synchronised before use.
// - A level interrupt stays pending until the source changes the input level.
// - The device keeps core, crystal reference and bus clock domains apart; only the core clock domain is built here.
// - Three active-low test inputs, tied statically, encode the test mode.
package ppm_pkg;

  localparam int CLK_MHZ         = 50;
  localparam int STRETCH_NOPLL   = 512;
  localparam int PLL_LOCK_US     = 100;
  localparam int PLL_LOCK_CYC    = PLL_LOCK_US * CLK_MHZ;
  localparam int CNT_W           = 24;
  localparam logic [3:0] RATIO_RST = 4'h1;
  localparam int IRQ_LSB         = 0;
  localparam int RST_PIN         = 4;

  // Per-pin function select
  typedef enum logic [1:0] {
    PPM_SEL_GP  = 2'h0,
    PPM_SEL_SER = 2'h1,
    PPM_SEL_ALT = 2'h2,
    PPM_SEL_RST = 2'h3
  } ppm_sel_t;

  // Test mode decode from the three strap inputs
  typedef enum logic [2:0] {
    PPM_TM_FUNC = 3'h0,
    PPM_TM_PLL  = 3'h1,
    PPM_TM_BIST = 3'h2,
    PPM_TM_SCAN = 3'h3,
    PPM_TM_MFG  = 3'h4
  } ppm_tmode_t;

  // One eight-bit port worth of pin drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ppm_drive_t;

endpackage

// *** core/ppm_sync.sv ***
// Purpose: Two-stage synchroniser for a vector of asynchronous levels
// Assumes: Inputs bear no relation to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ppm_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppm_sync_st_t;

  ppm_sync_st_t st;
  ppm_sync_st_t next_st;

  // Shift through two flops
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule

// *** core/ppm_top.sv ***
// Purpose: Pin-level mux of two general ports, reset-state output, level interrupts
// Assumes: Peripheral functions arrive as plain signals on the core clock
// Notes:   Only the core clock domain is built here; no other clock enters this block
`timescale 1ns/1ps
module ppm_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Configuration
  input  wire logic                      pll_en,
  input  wire logic [3:0]                vco_ratio,
  input  wire ppm_pkg::ppm_sel_t [7:0]   first_sel,
  input  wire ppm_pkg::ppm_sel_t [7:0]   second_sel,
  // Test straps, active low
  input  wire logic                      pll_test_sel_n,
  input  wire logic                      selftest_sel_n,
  input  wire logic                      scan_sel_n,
  output ppm_pkg::ppm_tmode_t            test_mode,
  // Function sources per port
  input  wire ppm_pkg::ppm_drive_t       first_gp,
  input  wire ppm_pkg::ppm_drive_t       first_ser,
  input  wire ppm_pkg::ppm_drive_t       first_alt,
  input  wire ppm_pkg::ppm_drive_t       second_gp,
  input  wire ppm_pkg::ppm_drive_t       second_ser,
  input  wire ppm_pkg::ppm_drive_t       second_alt,
  // Pins
  input  wire logic [7:0]                first_gp_port_in,
  output logic [7:0]                     first_gp_port_out,
  output logic [7:0]                     first_gp_port_oe,
  input  wire logic [7:0]                second_gp_port_in,
  output logic [7:0]                     second_gp_port_out,
  output logic [7:0]                     second_gp_port_oe,
  // Core side
  output logic [7:0]                     first_pin_val,
  output logic [7:0]                     second_pin_val,
  output logic [3:0]                     level_irq,
  output logic                           in_reset
);

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN     = 3'b100
  } ppm_state_t;

  typedef struct packed {
    ppm_state_t          state;
    logic [23:0]         cnt;
    ppm_pkg::ppm_drive_t p1;
    ppm_pkg::ppm_drive_t p2;
    logic [7:0]          v1;
    logic [7:0]          v2;
    ppm_pkg::ppm_tmode_t tm;
  } ppm_st_t;

  ppm_st_t    st;
  ppm_st_t    next_st;
  logic [3:0] irq_sync;

  // Select one drive source for a pin
  function automatic logic [1:0] pick(input ppm_pkg::ppm_sel_t s,
                                      input ppm_pkg::ppm_drive_t g,
                                      input ppm_pkg::ppm_drive_t r,
                                      input ppm_pkg::ppm_drive_t a,
                                      input int i);
    case (s)
      ppm_pkg::PPM_SEL_SER: pick = {r.out[i], r.oe[i]};
      ppm_pkg::PPM_SEL_ALT: pick = {a.out[i], a.oe[i]};
      default:              pick = {g.out[i], g.oe[i]};
    endcase
  endfunction

  // Stretch length for the current PLL setting
  function automatic logic [23:0] stretch_len(input logic pe, input logic [3:0] r);
    if (pe) begin
      stretch_len = 24'(ppm_pkg::PLL_LOCK_CYC * int'(r));
    end else begin
      stretch_len = 24'(ppm_pkg::STRETCH_NOPLL);
    end
  endfunction

  // Synchronise the level interrupt inputs
  ppm_sync #(
    .W (4)
  ) u_irq_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (second_gp_port_in[3:0]),
    .sync_out (irq_sync)
  );

  // Next state: reset stretch, pin mux, test decode
  always_comb begin
    next_st = st;
    case (st.state)
      ST_HOLD: begin
        next_st.cnt   = 24'h000001;
        next_st.state = ST_STRETCH;
      end
      ST_STRETCH: begin
        if (st.cnt >= stretch_len(pll_en, vco_ratio)) begin
          next_st.state = ST_RUN;
        end else begin
          next_st.cnt = st.cnt + 24'h000001;
        end
      end
      ST_RUN: begin
        next_st.cnt = st.cnt;
      end
      default: begin
        next_st.state = ST_HOLD;
      end
    endcase
    for (int i = 0; i < 8; i++) begin
      {next_st.p1.out[i], next_st.p1.oe[i]} =
        pick(first_sel[i], first_gp, first_ser, first_alt, i);
      {next_st.p2.out[i], next_st.p2.oe[i]} =
        pick(second_sel[i], second_gp, second_ser, second_alt, i);
    end
    if (st.state != ST_RUN || second_sel[ppm_pkg::RST_PIN] == ppm_pkg::PPM_SEL_RST) begin
      next_st.p2.out[ppm_pkg::RST_PIN] = (next_st.state != ST_RUN);
      next_st.p2.oe[ppm_pkg::RST_PIN]  = 1'b1;
    end
    next_st.v1 = first_gp_port_in;
    next_st.v2 = second_gp_port_in;
    case ({pll_test_sel_n, selftest_sel_n, scan_sel_n})
      3'h7:    next_st.tm = ppm_pkg::PPM_TM_FUNC;
      3'h3:    next_st.tm = ppm_pkg::PPM_TM_PLL;
      3'h5:    next_st.tm = ppm_pkg::PPM_TM_BIST;
      3'h6:    next_st.tm = ppm_pkg::PPM_TM_SCAN;
      default: next_st.tm = ppm_pkg::PPM_TM_MFG;
    endcase
  end

  // State register; reset drives pin 4 active output
  always_ff @(posedge clk) begin
    if (rst) begin
      st.state <= ST_HOLD;
      st.cnt   <= '0;
      st.p1    <= '0;
      st.p2    <= 16'h1010;
      st.v1    <= '0;
      st.v2    <= '0;
      st.tm    <= ppm_pkg::PPM_TM_FUNC;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign first_gp_port_out  = st.p1.out;
  assign first_gp_port_oe   = st.p1.oe;
  assign second_gp_port_out = st.p2.out;
  assign second_gp_port_oe  = st.p2.oe;
  assign first_pin_val      = st.v1;
  assign second_pin_val     = st.v2;
  assign test_mode          = st.tm;
  assign in_reset           = (st.state != ST_RUN);
  // Pending while the level stands, gated by selection
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level_irq[i] = irq_sync[i] && (second_sel[i] == ppm_pkg::PPM_SEL_ALT);
    end
  end

  // Reset output driven high in the same cycle as the reset state
  a_rst_pin_held: assert property (@(posedge clk) disable iff (rst)
    in_reset |-> second_gp_port_oe[4] && second_gp_port_out[4])
    else $error("reset pin not held during reset");

  // Stretch without PLL does not end before the count
  a_nopll_len: assert property (@(posedge clk) disable iff (rst)
    (st.state == ST_STRETCH && !pll_en && st.cnt < 24'(ppm_pkg::STRETCH_NOPLL)) |=> in_reset)
    else $error("stretch ended early without pll");

  // PLL stretch not shorter than lock time
  a_pll_len: assert property (@(posedge clk) disable iff (rst)
    (st.state == ST_STRETCH && pll_en && vco_ratio != 4'h0 &&
     st.cnt < 24'(ppm_pkg::PLL_LOCK_CYC)) |=> in_reset)
    else $error("stretch ended early with pll");

  // Leaving reset without PLL only once the count is reached
  a_stretch_exit: assert property (@(posedge clk) disable iff (rst)
    $fell(in_reset) |-> $past(st.cnt) >= 24'(ppm_pkg::STRETCH_NOPLL) || $past(pll_en))
    else $error("stretch exit without count");

  // Interrupt follows sync input two cycles later
  a_irq_follow: assert property (@(posedge clk) disable iff (rst)
    ##2 (second_sel[0] == ppm_pkg::PPM_SEL_ALT && $stable(second_sel[0]))
      |-> level_irq[0] == $past(second_gp_port_in[0], 2))
    else $error("interrupt not synchronised");

  // Functional test mode follows all-high straps
  a_test_func: assert property (@(posedge clk) disable iff (rst)
    (pll_test_sel_n && selftest_sel_n && scan_sel_n) |=> test_mode == ppm_pkg::PPM_TM_FUNC)
    else $error("functional mode not decoded");

  // Serial select routes serial drive
  a_mux_ser: assert property (@(posedge clk) disable iff (rst)
    (first_sel[7] == ppm_pkg::PPM_SEL_SER) |=> first_gp_port_out[7] == $past(first_ser.out[7]))
    else $error("serial route wrong");

  // Interrupt idle when not selected
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    (second_sel[1] == ppm_pkg::PPM_SEL_GP) |-> !level_irq[1])
    else $error("interrupt leaked");

endmodule

// *** tb/ppm_board.sv ***
// Purpose: Board-side model of interrupt sources, pulled port lines, straps
// Assumes: Sources change just after a rising edge
// Notes:   A source keeps its level until the bench drops it
`timescale 1ns/1ps
module ppm_board (
  // Clock
  input  wire logic       clk,
  // Requested levels
  input  wire logic [3:0] irq_cmd,
  input  wire logic [2:0] straps,
  // Pins seen by the device
  output logic      [7:0] first_in,
  output logic      [7:0] second_in,
  output logic            pll_test_sel_n,
  output logic            selftest_sel_n,
  output logic            scan_sel_n
);
  // Level sources hold until removed, changing 3 ns after each core clock rising edge
  always @(posedge clk) second_in <= #3 {4'h6, irq_cmd};
  // Lines pulled to a fixed pattern
  assign first_in = 8'h96;
  // Straps tied statically on the board
  assign {pll_test_sel_n, selftest_sel_n, scan_sel_n} = straps;
endmodule

// *** tb/port_pin_mux_reset_irq_tb.sv ***
// Purpose: Self-checking bench for the port pin mux and reset block
// Assumes: 50 MHz clock, sync reset held 10 cycles
// Notes:   Stretch windows allow a few cycles of slack
`timescale 1ns/1ps
module port_pin_mux_reset_irq_tb;
  logic clk = 1'b0, rst = 1'b1, pll_en = 1'b0, inr;
  logic [3:0] vco_ratio = 4'h1, irq_cmd = 4'h0, lirq;
  logic [2:0] straps = 3'h7;
  logic [7:0] fin, sin, fout, foe, sout, soe, fval, sval;
  logic ps, bs, ss_n;
  ppm_pkg::ppm_sel_t [7:0] first_sel, second_sel;
  ppm_pkg::ppm_drive_t fg = {8'h5a, 8'h0f}, fs = {8'ha5, 8'hf0}, fa = {8'h3c, 8'hcc};
  ppm_pkg::ppm_tmode_t tm;
  int n_mismatch = 0, total_checks = 0, cyc = 0;

  // Clock
  always #10 clk = ~clk;
  ppm_board board (.clk(clk), .irq_cmd(irq_cmd), .straps(straps), .first_in(fin),
    .second_in(sin), .pll_test_sel_n(ps), .selftest_sel_n(bs), .scan_sel_n(ss_n));
  ppm_top dut (.clk(clk), .rst(rst), .pll_en(pll_en), .vco_ratio(vco_ratio),
    .first_sel(first_sel), .second_sel(second_sel), .pll_test_sel_n(ps),
    .selftest_sel_n(bs), .scan_sel_n(ss_n), .test_mode(tm), .first_gp(fg),
    .first_ser(fs), .first_alt(fa), .second_gp(fg), .second_ser(fs), .second_alt(fa),
    .first_gp_port_in(fin), .first_gp_port_out(fout), .first_gp_port_oe(foe),
    .second_gp_port_in(sin), .second_gp_port_out(sout), .second_gp_port_oe(soe),
    .first_pin_val(fval), .second_pin_val(sval), .level_irq(lirq), .in_reset(inr));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reset then time the stretch
  task automatic reset_stretch(input logic pll, input logic [3:0] r, input int n);
    int k;
    @(posedge clk);
    rst <= 1'b1;
    pll_en <= pll;
    vco_ratio <= r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    k = 0;
    @(negedge clk);
    while (inr === 1'b1 && k < n + 20) begin
      if (k == n - 4) chk({soe[4], sout[4]}, 16'h3);
      @(negedge clk);
      k++;
    end
    chk({15'h0, k >= n && k <= n + 3}, 16'h1);
    @(negedge clk);
    chk({soe[4], sout[4], inr}, 16'h4);
  endtask

  // The GP, serial and alternate select codes each route their source
  task automatic mux_walk();
    ppm_pkg::ppm_drive_t exp [3];
    exp = '{fg, fs, fa};
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      first_sel <= {8{ppm_pkg::ppm_sel_t'(s)}};
      second_sel[7:5] <= {3{ppm_pkg::ppm_sel_t'(s)}};
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({fout, foe}, exp[s]);
      chk({10'h0, sout[7:5], soe[7:5]}, {10'h0, exp[s].out[7:5], exp[s].oe[7:5]});
      chk({8'h0, fval}, 16'h96);
      chk({8'h0, sval}, 16'h60);
    end
  endtask

  // Level interrupts: held while level stands, gone when dropped
  task automatic irq_level();
    @(posedge clk);
    second_sel[3:0] <= {4{ppm_pkg::PPM_SEL_ALT}};
    irq_cmd <= 4'ha;
    repeat (25) @(posedge clk);
    @(negedge clk);
    chk({12'h0, lirq}, 16'ha);
    @(posedge clk);
    irq_cmd <= 4'h5;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({12'h0, lirq}, 16'h5);
    @(posedge clk);
    irq_cmd <= 4'hf;
    second_sel[3:0] <= {4{ppm_pkg::PPM_SEL_GP}};
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({12'h0, lirq}, 16'h0);
  endtask

  // Strap codes to test modes
  task automatic strap_modes();
    logic [2:0] code [5] = '{3'h7, 3'h3, 3'h5, 3'h6, 3'h0};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      straps <= code[i];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({13'h0, tm}, i);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end

  // Main sequence
  initial begin
    first_sel = {8{ppm_pkg::PPM_SEL_GP}};
    second_sel = {8{ppm_pkg::PPM_SEL_GP}};
    second_sel[4] = ppm_pkg::PPM_SEL_RST;
    reset_stretch(1'b0, 4'h1, ppm_pkg::STRETCH_NOPLL);
    mux_walk();
    irq_level();
    strap_modes();
    reset_stretch(1'b1, 4'h1, ppm_pkg::PLL_LOCK_CYC);
    reset_stretch(1'b1, 4'h2, 2 * ppm_pkg::PLL_LOCK_CYC);
    results();
  end
endmodule
